// file: src/power_monitor_control.sv
// power monitor control and status block behind a classic wishbone slave
// assumes: comparator, stop and wake inputs are synchronous to clk_i;
// por_i is high together with rst_i only for a power-on reset
//
// Behaviour
// R1: detect flag sets on comparator event when enabled
// R2: detect ack write 1 clears flag, reads 0
// R3: interrupt request while flag and irq enable
// R4: reset request when flag rises with reset enable
// R5: stop enable keeps detection running in stop
// R6: logic enable gates flag, irq, reset, stop
// R7: software writes reserved bit 1 as zero
// R8: reference buffer enable drives buffer output
// R9: warning flag sets while supply below warning point
// R10: warning ack clears only if warning absent
// R11: detect trip select picks high or low point
// R12: warning trip select picks high or low point
// R13: trip selects write once, cleared only by power-on
// R14: power-down flag sets on partial power-down wake
// R15: power-down ack write 1 clears flag, reads 0
// R16: power-down select writable once after reset
// R17: watchdog clock select writable once after reset
// R18: timer routing picks shared or dedicated clocks
// R19: any reset clears second register volatile bits
// R20: software acks power-down before touching i/o
// R21: set beats acknowledge in the same cycle
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "power_monitor_control_regs.svh"

module power_monitor_control (
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_i,
  input  wire logic                                  por_i,
  // wishbone slave
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire power_monitor_control_pkg::bus_addr_t  wb_adr_i,
  input  wire power_monitor_control_pkg::bus_sel_t   wb_sel_i,
  input  wire power_monitor_control_pkg::bus_data_t  wb_dat_i,
  output power_monitor_control_pkg::bus_data_t       wb_dat_o,
  output logic                                       wb_ack_o,
  // analog side
  input  wire logic                                  undervolt_detect_i,
  input  wire logic                                  supply_warning_i,
  input  wire logic                                  stop_mode_i,
  input  wire logic                                  partial_powerdown_wake_i,
  // timer clock pins
  input  wire logic                                  irq_pin_clock_i,
  input  wire logic                                  shared_timer_ext_clock_i,
  input  wire logic                                  timer_one_ext_clock_i,
  input  wire logic                                  timer_two_ext_clock_i,
  // controls toward the chip
  output logic                                       undervolt_irq_o,
  output logic                                       chip_reset_req_o,
  output logic                                       detector_enable_o,
  output logic                                       reference_buffer_enable_o,
  output logic                                       detect_trip_select_o,
  output logic                                       warning_trip_select_o,
  output logic                                       partial_powerdown_select_o,
  output logic                                       watchdog_clock_select_o,
  output logic                                       timer_one_clock_o,
  output logic                                       timer_two_clock_o,
  output logic                                       timer_three_clock_o
);
  import power_monitor_control_pkg::*;

  // ============================================================
  // address decode
  function automatic reg_sel_t decode_addr(input bus_addr_t addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    case (addr)
      `PMC_CTRL1_OFFSET: sel = SEL_CTRL1;
      `PMC_CTRL2_OFFSET: sel = SEL_CTRL2;
      `PMC_OPT2_OFFSET:  sel = SEL_OPT2;
      default:           sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // ============================================================
  // bus handshake
  bus_state_t bus_state_reg;   // handshake state
  bus_state_t bus_state_next;  // next handshake state
  logic       bus_req;         // new request taken this cycle
  logic       wr_byte;         // write with the low lane enabled
  reg_sel_t   req_sel;         // decoded target of the request
  logic [7:0] wbyte;           // low write byte
  logic       wr_ctrl1;        // write into first control register
  logic       wr_ctrl2;        // write into second control register
  logic       wr_opt2;         // write into option register

  assign bus_req  = wb_cyc_i & wb_stb_i & (bus_state_reg == BUS_IDLE);
  assign wr_byte  = bus_req & wb_we_i & wb_sel_i[0];
  assign req_sel  = decode_addr(wb_adr_i);
  assign wbyte    = wb_dat_i[7:0];
  assign wr_ctrl1 = wr_byte & (req_sel == SEL_CTRL1);
  assign wr_ctrl2 = wr_byte & (req_sel == SEL_CTRL2);
  assign wr_opt2  = wr_byte & (req_sel == SEL_OPT2);

  // next handshake state: one ack cycle per request
  always_comb begin
    bus_state_next = BUS_IDLE;
    case (bus_state_reg)
      BUS_IDLE: begin
        // request seen, answer next cycle
        if (wb_cyc_i && wb_stb_i) begin
          bus_state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        // ack lasts one cycle, then back to idle
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // handshake state and ack flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state_reg <= BUS_IDLE;
      wb_ack_o      <= 1'b0;
    end else begin
      bus_state_reg <= bus_state_next;
      wb_ack_o      <= (bus_state_next == BUS_ACK);
    end
  end

  // ============================================================
  // first control register
  logic det_flag_reg;   // undervolt_detect_flag
  logic irq_en_reg;     // undervolt_irq_enable
  logic rst_en_reg;     // undervolt_reset_enable
  logic stop_en_reg;    // undervolt_stop_enable
  logic logic_en_reg;   // undervolt_logic_enable
  logic refbuf_reg;     // reference_buffer_enable
  logic det_active;     // detector running this cycle
  logic det_set;        // detect event taken
  logic det_clr;        // undervolt_detect_ack written as one

  // detection runs when enabled, and in stop only with stop enable
  assign det_active = logic_en_reg & (~stop_mode_i | stop_en_reg);  // see R5 see R6
  assign det_set    = det_active & undervolt_detect_i;               // see R1
  assign det_clr    = wr_ctrl1 & wbyte[`PMC_C1_DET_ACK_BIT];         // see R2

  // read/write enables; reserved bit is never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg   <= 1'(`PMC_CTRL1_RESET >> `PMC_C1_IRQ_EN_BIT);
      rst_en_reg   <= 1'(`PMC_CTRL1_RESET >> `PMC_C1_RST_EN_BIT);
      stop_en_reg  <= 1'(`PMC_CTRL1_RESET >> `PMC_C1_STOP_EN_BIT);
      logic_en_reg <= 1'(`PMC_CTRL1_RESET >> `PMC_C1_LOGIC_EN_BIT);
      refbuf_reg   <= 1'(`PMC_CTRL1_RESET >> `PMC_C1_REFBUF_BIT);
    end else if (wr_ctrl1) begin
      // bit 1 is dropped, software keeps it zero (see R7)
      irq_en_reg   <= wbyte[`PMC_C1_IRQ_EN_BIT];
      rst_en_reg   <= wbyte[`PMC_C1_RST_EN_BIT];
      stop_en_reg  <= wbyte[`PMC_C1_STOP_EN_BIT];
      logic_en_reg <= wbyte[`PMC_C1_LOGIC_EN_BIT];
      refbuf_reg   <= wbyte[`PMC_C1_REFBUF_BIT];  // see R8
    end
  end

  // sticky detect flag; a set in the ack cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      det_flag_reg <= 1'b0;
    end else if (det_set) begin
      det_flag_reg <= 1'b1;  // see R1 see R21
    end else if (det_clr) begin
      det_flag_reg <= 1'b0;  // see R2
    end
  end

  // ============================================================
  // second control register
  logic warn_flag_reg;     // supply_warning_flag
  logic det_trip_reg;      // detect_trip_select
  logic warn_trip_reg;     // warning_trip_select
  logic trip_locked_reg;   // trip selects already written since power-on
  logic ppd_flag_reg;      // partial_powerdown_flag
  logic ppd_sel_reg;       // partial_powerdown_select
  logic ppd_locked_reg;    // power-down select already written
  logic warn_clr;          // supply_warning_ack written as one
  logic ppd_clr;           // partial_powerdown_ack written as one

  assign warn_clr = wr_ctrl2 & wbyte[`PMC_C2_WARN_ACK_BIT];
  assign ppd_clr  = wr_ctrl2 & wbyte[`PMC_C2_PPD_ACK_BIT];

  // warning flag: sets while the warning stands, ack needs it gone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      warn_flag_reg <= 1'b0;  // see R19
    end else if (supply_warning_i) begin
      // also catches a supply already low right after reset
      warn_flag_reg <= 1'b1;  // see R9 see R21
    end else if (warn_clr) begin
      warn_flag_reg <= 1'b0;  // see R10
    end
  end

  // trip selects survive every reset except power-on
  always_ff @(posedge clk_i) begin
    if (rst_i && por_i) begin
      det_trip_reg    <= 1'b0;  // see R13
      warn_trip_reg   <= 1'b0;
      trip_locked_reg <= 1'b0;
    end else if (!rst_i && wr_ctrl2 && !trip_locked_reg) begin
      // first write after power-on is taken, later ones ignored
      det_trip_reg    <= wbyte[`PMC_C2_DET_TRIP_BIT];   // see R11 see R13
      warn_trip_reg   <= wbyte[`PMC_C2_WARN_TRIP_BIT];  // see R12
      trip_locked_reg <= 1'b1;
    end
  end

  // power-down flag: set on wake from partial power-down
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ppd_flag_reg <= 1'b0;  // see R19
    end else if (partial_powerdown_wake_i) begin
      ppd_flag_reg <= 1'b1;  // see R14 see R21
    end else if (ppd_clr) begin
      // software acks before touching i/o again (see R20)
      ppd_flag_reg <= 1'b0;  // see R15
    end
  end

  // power-down select, write once after any reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ppd_sel_reg    <= 1'b0;  // see R19
      ppd_locked_reg <= 1'b0;
    end else if (wr_ctrl2 && !ppd_locked_reg) begin
      ppd_sel_reg    <= wbyte[`PMC_C2_PPD_SEL_BIT];  // see R16
      ppd_locked_reg <= 1'b1;
    end
  end

  // ============================================================
  // option register
  logic wdog_sel_reg;     // watchdog_clock_select
  logic wdog_locked_reg;  // watchdog select already written
  logic timer_rt_reg;     // timer_clock_routing

  // watchdog select write once, routing freely writable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_sel_reg    <= 1'(`PMC_OPT2_RESET >> `PMC_O2_WDOG_SEL_BIT);
      wdog_locked_reg <= 1'b0;
      timer_rt_reg    <= 1'(`PMC_OPT2_RESET >> `PMC_O2_TIMER_RT_BIT);
    end else if (wr_opt2) begin
      if (!wdog_locked_reg) begin
        wdog_sel_reg    <= wbyte[`PMC_O2_WDOG_SEL_BIT];  // see R17
        wdog_locked_reg <= 1'b1;
      end
      timer_rt_reg <= wbyte[`PMC_O2_TIMER_RT_BIT];  // see R18
    end
  end

  // ============================================================
  // read data
  logic [7:0] rbyte;  // low read byte for the decoded register

  // assemble read byte; ack bits and unused bits read zero
  always_comb begin
    rbyte = 8'h00;
    case (req_sel)
      SEL_CTRL1: begin
        rbyte[`PMC_C1_DET_FLAG_BIT] = det_flag_reg;
        rbyte[`PMC_C1_IRQ_EN_BIT]   = irq_en_reg;
        rbyte[`PMC_C1_RST_EN_BIT]   = rst_en_reg;
        rbyte[`PMC_C1_STOP_EN_BIT]  = stop_en_reg;
        rbyte[`PMC_C1_LOGIC_EN_BIT] = logic_en_reg;
        rbyte[`PMC_C1_REFBUF_BIT]   = refbuf_reg;
      end
      SEL_CTRL2: begin
        rbyte[`PMC_C2_WARN_FLAG_BIT] = warn_flag_reg;
        rbyte[`PMC_C2_DET_TRIP_BIT]  = det_trip_reg;
        rbyte[`PMC_C2_WARN_TRIP_BIT] = warn_trip_reg;
        rbyte[`PMC_C2_PPD_FLAG_BIT]  = ppd_flag_reg;
        rbyte[`PMC_C2_PPD_SEL_BIT]   = ppd_sel_reg;
      end
      SEL_OPT2: begin
        rbyte[`PMC_O2_WDOG_SEL_BIT] = wdog_sel_reg;
        rbyte[`PMC_O2_TIMER_RT_BIT] = timer_rt_reg;
      end
      default: begin
        // unmapped address answers zero
        rbyte = 8'h00;
      end
    endcase
  end

  // read data captured when the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req) begin
      wb_dat_o <= {24'h00_0000, (wb_we_i ? 8'h00 : rbyte)};  // see R2 see R10 see R15
    end
  end

  // ============================================================
  // outputs toward the chip
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      undervolt_irq_o            <= 1'b0;
      chip_reset_req_o           <= 1'b0;
      detector_enable_o          <= 1'b0;
      reference_buffer_enable_o  <= 1'b0;
      detect_trip_select_o       <= 1'b0;
      warning_trip_select_o      <= 1'b0;
      partial_powerdown_select_o <= 1'b0;
      watchdog_clock_select_o    <= 1'b0;
    end else begin
      undervolt_irq_o            <= det_flag_reg & irq_en_reg & logic_en_reg;  // see R3 see R6
      // one-cycle request as the flag goes from zero to one
      chip_reset_req_o           <= det_set & ~det_flag_reg & rst_en_reg & logic_en_reg;  // see R4
      detector_enable_o          <= det_active;    // see R5
      reference_buffer_enable_o  <= refbuf_reg;    // see R8
      detect_trip_select_o       <= det_trip_reg;  // see R11
      warning_trip_select_o      <= warn_trip_reg; // see R12
      partial_powerdown_select_o <= ppd_sel_reg;   // see R16
      watchdog_clock_select_o    <= wdog_sel_reg;  // see R17
    end
  end

  // timer clock routing, one flop of delay on every path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_one_clock_o   <= 1'b0;
      timer_two_clock_o   <= 1'b0;
      timer_three_clock_o <= 1'b0;
    end else if (timer_rt_reg) begin
      timer_one_clock_o   <= timer_one_ext_clock_i;     // see R18
      timer_two_clock_o   <= timer_two_ext_clock_i;
      timer_three_clock_o <= shared_timer_ext_clock_i;
    end else begin
      timer_one_clock_o   <= irq_pin_clock_i;           // see R18
      timer_two_clock_o   <= irq_pin_clock_i;
      timer_three_clock_o <= irq_pin_clock_i;
    end
  end

  // ============================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_det_flag_set: assert property (det_set |=> det_flag_reg [*1]) // see R1
    else $error("detect flag missed an event");
  a_det_ack_clear: assert property (det_clr && !det_set |=> !det_flag_reg) // see R2
    else $error("detect ack did not clear flag");
  a_ack_bits_zero: assert property (wb_ack_o |-> wb_dat_o[6] == 1'b0 && wb_dat_o[1] == 1'b0) // see R7
    else $error("ack or reserved bit read as one");
  a_irq_request: assert property (
      (det_flag_reg && irq_en_reg && logic_en_reg) [*2] |-> undervolt_irq_o) // see R3
    else $error("interrupt request missing");
  a_reset_on_rise: assert property (
      $rose(det_flag_reg) && $past(rst_en_reg && logic_en_reg) |-> chip_reset_req_o) // see R4
    else $error("reset request missing on flag rise");
  a_stop_gating: assert property (
      stop_mode_i && !stop_en_reg && !det_flag_reg |=> !det_flag_reg) // see R5
    else $error("detect flag set during stop without stop enable");
  a_logic_gate: assert property (
      !logic_en_reg |=> !chip_reset_req_o && !undervolt_irq_o && !detector_enable_o) // see R6
    else $error("disabled detect logic still active");
  a_refbuf_write: assert property (
      wr_ctrl1 |-> ##2 reference_buffer_enable_o == $past(wbyte[0], 2)) // see R8
    else $error("reference buffer does not follow write");
  a_warn_set: assert property (supply_warning_i |=> warn_flag_reg) // see R9
    else $error("warning flag not set");
  a_warn_ack: assert property (warn_clr && !supply_warning_i |=> !warn_flag_reg) // see R10
    else $error("warning ack did not clear flag");
  a_trip_locked: assert property (
      trip_locked_reg |=> $stable(det_trip_reg) && $stable(warn_trip_reg)) // see R13
    else $error("trip select changed after first write");
  a_ppd_ack: assert property (ppd_clr && !partial_powerdown_wake_i |=> !ppd_flag_reg) // see R15
    else $error("power-down ack did not clear flag");
  a_wdog_once: assert property (wdog_locked_reg |=> $stable(wdog_sel_reg)) // see R17
    else $error("watchdog select changed after first write");
  a_set_wins: assert property (det_set && det_clr |=> det_flag_reg) // see R21
    else $error("set lost against ack");
  a_bus_answer: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");

  c_set_and_ack: cover property (det_set && det_clr);
  c_reset_req:   cover property ($rose(chip_reset_req_o));
  c_trip_refuse: cover property (wr_ctrl2 && trip_locked_reg);
  c_ppd_cleared: cover property (ppd_flag_reg ##1 !ppd_flag_reg);
endmodule

// file: src/power_monitor_control_pkg.sv
// types shared by the power monitor block and its bench
// assumes: the register header sits beside this file
package power_monitor_control_pkg;
  // ============================================================
  // bus carrier types
  typedef logic [3:0]  bus_addr_t;   // byte address on the slave
  typedef logic [31:0] bus_data_t;   // wishbone data word
  typedef logic [3:0]  bus_sel_t;    // byte lane selects

  // ============================================================
  // slave handshake states
  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } bus_state_t;

  // ============================================================
  // decoded register selection
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CTRL1,
    SEL_CTRL2,
    SEL_OPT2
  } reg_sel_t;
endpackage

// file: src/power_monitor_control_regs.svh
// register offsets, field positions and reset values of the power monitor block
// assumes: included by bare name from the design file and the bench
`ifndef POWER_MONITOR_CONTROL_REGS_SVH
`define POWER_MONITOR_CONTROL_REGS_SVH

// ============================================================
// byte offsets on the wishbone slave
`define PMC_CTRL1_OFFSET      4'h0
`define PMC_CTRL2_OFFSET      4'h4
`define PMC_OPT2_OFFSET       4'h8

// ============================================================
// power_monitor_control_1 fields
`define PMC_C1_DET_FLAG_BIT   7
`define PMC_C1_DET_ACK_BIT    6
`define PMC_C1_IRQ_EN_BIT     5
`define PMC_C1_RST_EN_BIT     4
`define PMC_C1_STOP_EN_BIT    3
`define PMC_C1_LOGIC_EN_BIT   2
`define PMC_C1_RSVD_BIT       1
`define PMC_C1_REFBUF_BIT     0
`define PMC_CTRL1_RESET       8'h00

// ============================================================
// power_monitor_control_2 fields
`define PMC_C2_WARN_FLAG_BIT  7
`define PMC_C2_WARN_ACK_BIT   6
`define PMC_C2_DET_TRIP_BIT   5
`define PMC_C2_WARN_TRIP_BIT  4
`define PMC_C2_PPD_FLAG_BIT   3
`define PMC_C2_PPD_ACK_BIT    2
`define PMC_C2_PPD_SEL_BIT    0
`define PMC_CTRL2_RESET       8'h00

// ============================================================
// system_feature_options_2 fields
`define PMC_O2_WDOG_SEL_BIT   7
`define PMC_O2_TIMER_RT_BIT   3
`define PMC_OPT2_RESET        8'h00

`endif

// file: tb/supply_monitor_model.sv
// analog side stand-in: supply comparators, stop and wake status, timer clock pins
// assumes: the bench sets the wanted levels; outputs settle one clock later
`timescale 1ns/10ps

module supply_monitor_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] level_i,  // wake, stop, warning, detect requests
  input  wire logic [3:0] pins_i,   // irq pin, shared, timer one, timer two
  output logic      [3:0] analog_o, // comparator and mode levels
  output logic      [3:0] pins_o    // timer clock pin levels
);
  // ============================================================
  // comparator settling: one clock from request to level
  always_ff @(posedge clk_i) begin
    analog_o <= level_i;
    pins_o   <= pins_i;
  end
endmodule

// file: tb/test_power_monitor_control.sv
// self-checking bench for the power monitor block over classic wishbone
// assumes: design, package and register header compiled first
`timescale 1ns/10ps
`include "power_monitor_control_regs.svh"

module test_power_monitor_control;
  import power_monitor_control_pkg::*;
  // ============================================================
  // bench signals
  logic        clk_i, rst_i, por_i, cyc, stb, we;
  bus_addr_t   adr;
  bus_data_t   dat, wb_dat_o;
  logic        wb_ack_o, det, warn, stp, wake, irq, crq, den, rbe, dts, wts, pps, wcs;
  logic [2:0]  tmr;
  logic [3:0]  ana, pin, pin_lvl;
  int          mismatches, num_checks, cycles, pulses;
  localparam bus_addr_t A1 = `PMC_CTRL1_OFFSET;
  localparam bus_addr_t A2 = `PMC_CTRL2_OFFSET;
  localparam bus_addr_t A3 = `PMC_OPT2_OFFSET;

  supply_monitor_model far (.clk_i(clk_i), .level_i({wake, stp, warn, det}),
    .pins_i(pin_lvl), .analog_o(ana), .pins_o(pin));

  power_monitor_control dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .undervolt_detect_i(ana[0]), .supply_warning_i(ana[1]), .stop_mode_i(ana[2]),
    .partial_powerdown_wake_i(ana[3]), .irq_pin_clock_i(pin[3]),
    .shared_timer_ext_clock_i(pin[2]), .timer_one_ext_clock_i(pin[1]),
    .timer_two_ext_clock_i(pin[0]), .undervolt_irq_o(irq), .chip_reset_req_o(crq),
    .detector_enable_o(den), .reference_buffer_enable_o(rbe),
    .detect_trip_select_o(dts), .warning_trip_select_o(wts),
    .partial_powerdown_select_o(pps), .watchdog_clock_select_o(wcs),
    .timer_one_clock_o(tmr[2]), .timer_two_clock_o(tmr[1]), .timer_three_clock_o(tmr[0]));

  // ============================================================
  // clock, hang guard and reset pulse counter
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (crq === 1'b1) pulses++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end

  // ============================================================
  // bus and compare tasks
  task automatic wb_xfer(input logic w, input bus_addr_t a, input logic [7:0] d,
                         output logic [7:0] q);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d};
    // wait for ack however long it takes; only the bench timeout ends a hang
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wr(input bus_addr_t a, input logic [7:0] d);
    logic [7:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task automatic chk_reg(input bus_addr_t a, input logic [7:0] e);
    logic [7:0] q;
    wb_xfer(1'b0, a, 8'h00, q);
    num_checks++;
    if (q !== e) begin
      mismatches++;
      $display("wrong value at %0t: reg %h read %h expected %h", $time, a, q, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic hop(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic reset(input logic p);
    @(posedge clk_i);
    rst_i <= 1'b1; por_i <= p;
    hop(2);
    rst_i <= 1'b0; por_i <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ============================================================
  // test sequence
  initial begin
    {cyc, stb, we, det, warn, stp, wake} = '0;
    adr = '0; dat = '0; rst_i = 1'b1; por_i = 1'b1; pin_lvl = 4'hA;
    mismatches = 0; num_checks = 0; cycles = 0; pulses = 0;
    hop(2);
    rst_i <= 1'b0; por_i <= 1'b0;
    chk_reg(A1, 8'h00); chk_reg(A2, 8'h00); chk_reg(A3, 8'h00);
    $display("test reset values done");
    wr(A1, 8'h3D);
    chk_reg(A1, 8'h3D);
    chk_bit(rbe, 1'b1, "buffer enable");
    det <= 1'b1; hop(4);
    chk_bit(irq, 1'b1, "irq");
    wr(A1, 8'h7D);
    chk_reg(A1, 8'hBD);
    det <= 1'b0; hop(2);
    wr(A1, 8'h7D);
    chk_reg(A1, 8'h3D); hop(2);
    chk_bit(irq, 1'b0, "irq clear");
    chk_bit(pulses == 1, 1'b1, "reset pulse count");
    $display("test detect done");
    wr(A1, 8'h40); det <= 1'b1; hop(4);
    chk_reg(A1, 8'h00);
    det <= 1'b0; wr(A1, 8'h04); stp <= 1'b1; hop(3);
    chk_bit(den, 1'b0, "detector in stop");
    det <= 1'b1; hop(4);
    chk_reg(A1, 8'h04);
    det <= 1'b0; wr(A1, 8'h0C); hop(2);
    chk_bit(den, 1'b1, "detector stop enable");
    stp <= 1'b0;
    $display("test gating done");
    wr(A2, 8'h31); wr(A2, 8'h00);
    chk_reg(A2, 8'h31);
    chk_bit({dts, wts, pps} == 3'b111, 1'b1, "selects");
    warn <= 1'b1; hop(4); wr(A2, 8'h40);
    chk_reg(A2, 8'hB1);
    warn <= 1'b0; hop(3); wr(A2, 8'h40);
    chk_reg(A2, 8'h31);
    wake <= 1'b1; hop(2); wake <= 1'b0; hop(2);
    chk_reg(A2, 8'h39);
    wr(A2, 8'h04);
    chk_reg(A2, 8'h31);
    reset(1'b0);
    chk_reg(A2, 8'h30);
    wr(A2, 8'h01);
    chk_reg(A2, 8'h31);
    reset(1'b1);
    chk_reg(A2, 8'h00);
    $display("test second register done");
    wr(A3, 8'h88); hop(2);
    chk_reg(A3, 8'h88);
    chk_bit(tmr === 3'b100 && wcs === 1'b1, 1'b1, "dedicated clocks");
    pin_lvl <= 4'h6; hop(3);
    chk_bit(tmr === 3'b101, 1'b1, "dedicated pins apart");
    wr(A3, 8'h00); hop(2);
    chk_reg(A3, 8'h80);
    chk_bit(tmr === 3'b000, 1'b1, "shared clock low");
    pin_lvl <= 4'hA; hop(3);
    chk_bit(tmr === 3'b111, 1'b1, "shared clock");
    wr(4'hC, 8'hFF);
    chk_reg(4'hC, 8'h00);
    $display("test options done");
    test_done();
  end
endmodule
